// File: pkg/gpsg_pkg.sv
// package: register map, reset values and layout constants of the stop-gated gpio port
package gpsg_pkg;
    localparam int PIN_COUNT = 8;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;

    // register byte offsets
    localparam logic [ADDR_WIDTH-1:0] PIN_DATA_OFFSET = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] OUTPUT_ENABLE_OFFSET = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] FUNCTION_SELECT_OFFSET = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] OPEN_DRAIN_OFFSET = 8'h28;
    localparam logic [ADDR_WIDTH-1:0] PULLUP_OFFSET = 8'h2C;
    localparam logic [ADDR_WIDTH-1:0] PULLDOWN_OFFSET = 8'h30;
    localparam logic [ADDR_WIDTH-1:0] INPUT_ENABLE_OFFSET = 8'h38;
    localparam logic [ADDR_WIDTH-1:0] STANDBY_CONTROL_OFFSET = 8'h40;
    localparam logic [ADDR_WIDTH-1:0] PIN_LEVEL_OFFSET = 8'h44;

    // reset values
    localparam logic [PIN_COUNT-1:0] PIN_DATA_RESET = 8'h00;
    localparam logic [PIN_COUNT-1:0] OUTPUT_ENABLE_RESET = 8'h01;
    localparam logic [PIN_COUNT-1:0] FUNCTION_SELECT_RESET = 8'h03;
    localparam logic [PIN_COUNT-1:0] OPEN_DRAIN_RESET = 8'h00;
    localparam logic [PIN_COUNT-1:0] PULLUP_RESET = 8'h01;
    localparam logic [PIN_COUNT-1:0] PULLDOWN_RESET = 8'h02;
    localparam logic [PIN_COUNT-1:0] INPUT_ENABLE_RESET = 8'h03;

    // writable bit masks
    localparam logic [PIN_COUNT-1:0] FUNCTION_SELECT_MASK = 8'h7F;
    localparam logic [PIN_COUNT-1:0] PULLUP_MASK = 8'hFD;
    localparam logic [PIN_COUNT-1:0] PULLDOWN_MASK = 8'h02;

    // pin roles
    localparam logic [PIN_COUNT-1:0] DEBUG_OUT_PINS = 8'h01;
    localparam logic [PIN_COUNT-1:0] DEBUG_CLOCK_PINS = 8'h02;
    localparam logic [PIN_COUNT-1:0] INTERRUPT_PINS = 8'h00;

    // standby control bit positions
    localparam int STOP_BIT = 0;
    localparam int DRIVE_ENABLE_BIT = 1;
endpackage : gpsg_pkg

// File: rtl/gpsg_port.sv
// module: eight-pin gpio port with stop-mode gating and an avalon-mm register slave
`timescale 1ns/1ps

// Functional notes
// - eight pins, each independently input or output under software control.
// - data register holds output values; reads return port data.
// - output enable bit one drives its pin, zero releases it.
// - function select one routes the alternate function, zero keeps port use.
// - open-drain bit one suppresses high drive, giving pseudo open-drain.
// - pull-up register switches each pin pull-up on or off, except pin 1, which stays zero.
// - pull-down register switches only the pin 1 pull-down on or off.
// - input enable gates input path; defaults off except debug pins.
// - stop with drive-enable one: pins other than the debug output pin follow their own enables.
// - stop with drive-enable zero: ordinary pins lose input and output.
// - debug output pin drives when debug data valid, ignoring drive-enable.
// - interrupt pins keep input in stop; output needs drive-enable.
// - reset: pin 0 debug data pin with input, output, pull-up on.
// - reset: pin 1 debug clock with input and pull-down on.
// - reset: pins 2 to 7 plain port, input, output, pull-up off.
// - function register selects debug interface and trace outputs.
// - pull-down register: only bit 1 writable, others read zero.
// - input enable bits 7 to 0 enable each pin input.
module gpsg_port (
    // clock and synchronous reset
    input wire logic clock,
    input wire logic rst_n,
    // register bus, avalon-mm slave
    input wire logic [gpsg_pkg::ADDR_WIDTH-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [gpsg_pkg::DATA_WIDTH-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [gpsg_pkg::DATA_WIDTH-1:0] avs_readdata,
    output logic avs_waitrequest,
    // board pins; levels arrive asynchronous to clock
    input wire logic [gpsg_pkg::PIN_COUNT-1:0] pin_in,
    output logic [gpsg_pkg::PIN_COUNT-1:0] pin_out,
    output logic [gpsg_pkg::PIN_COUNT-1:0] pin_oe,
    output logic [gpsg_pkg::PIN_COUNT-1:0] pin_pullup,
    output logic [gpsg_pkg::PIN_COUNT-1:0] pin_pulldown,
    // core side: gated inputs and alternate function drive
    output logic [gpsg_pkg::PIN_COUNT-1:0] port_in_data,
    output logic [gpsg_pkg::PIN_COUNT-1:0] alt_in_data,
    input wire logic [gpsg_pkg::PIN_COUNT-1:0] alt_out_data,
    input wire logic [gpsg_pkg::PIN_COUNT-1:0] alt_out_enable,
    // debug and power control, same clock
    input wire logic debug_data_valid,
    input wire logic stop_request,
    output logic stop_active
);
    import gpsg_pkg::*;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    // pin data: output value; reads show port inputs or driven data
    // output enable: one drives the pin
    // function select: one hands the pin to its alternate function, bit 7 fixed
    // open drain: one releases a pin whose drive value is high
    // pull-up: bit 1 fixed zero, the debug clock pin only pulls down
    // pull-down: only bit 1 writable
    // input enable: one opens the input path; off by default except pins 0 and 1, against through current
    // standby control: bit 0 mirrors stop (read only), bit 1 drive-enable
    // pin level: raw synchronised levels, read only, not gated
    // every bit above the pin bits reads zero and ignores writes
    // reset: pin 0 debug data, pin 1 debug clock, pins 2 to 7 plain port
    // accesses answer after one wait cycle, then one forced idle cycle

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // bus slave: one answer cycle, then a forced idle cycle
    typedef enum {
        BUS_IDLE,
        BUS_ANSWER
    } gpsg_bus_state_t;

    // every flop of the block lives in this one word
    typedef struct packed {
        // bus slave position
        gpsg_bus_state_t bus_state;
        // software-visible registers
        logic [PIN_COUNT-1:0] pin_data_reg;
        logic [PIN_COUNT-1:0] output_enable_reg;
        logic [PIN_COUNT-1:0] function_select_reg;
        logic [PIN_COUNT-1:0] open_drain_reg;
        logic [PIN_COUNT-1:0] pullup_reg;
        logic [PIN_COUNT-1:0] pulldown_reg;
        logic [PIN_COUNT-1:0] input_enable_reg;
        // power control
        logic stop_reg;
        logic drive_enable_reg;
        // pin synchroniser, two stages
        logic [PIN_COUNT-1:0] sync_first;
        logic [PIN_COUNT-1:0] sync_second;
        // bus answer
        logic [DATA_WIDTH-1:0] readdata;
        logic waitrequest;
        // registered outputs
        logic [PIN_COUNT-1:0] out;
        logic [PIN_COUNT-1:0] oe;
        logic [PIN_COUNT-1:0] pu;
        logic [PIN_COUNT-1:0] pd;
        logic [PIN_COUNT-1:0] port_in;
        logic [PIN_COUNT-1:0] alt_in;
        logic stop_out;
    } gpsg_state_t;

    gpsg_state_t state_reg;
    gpsg_state_t state_next;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte-lane merge of the low lane into an eight-bit register, masking fixed bits
    // disabled lanes and fixed bits keep their old value
    function automatic logic [PIN_COUNT-1:0] lane_merge(
        input logic [PIN_COUNT-1:0] old_value,
        input logic [DATA_WIDTH-1:0] wdata,
        input logic lane0,
        input logic [PIN_COUNT-1:0] mask
    );
        logic [PIN_COUNT-1:0] merged;
        merged = lane0 ? wdata[PIN_COUNT-1:0] : old_value;
        return (merged & mask) | (old_value & ~mask);
    endfunction : lane_merge

    // zero-extend a pin-wide value to a bus word
    function automatic logic [DATA_WIDTH-1:0] widen(input logic [PIN_COUNT-1:0] v);
        return {{(DATA_WIDTH-PIN_COUNT){1'b0}}, v};
    endfunction : widen

    // stop with drive-enable clear: ordinary pins lose both paths
    function automatic logic stop_gated(
        input logic stop,
        input logic drive_enable
    );
        return stop && !drive_enable;
    endfunction : stop_gated

    // input paths kept alive while stop gating is in force;
    // interrupt pins must still wake the core, and none sit on this port
    function automatic logic [PIN_COUNT-1:0] stop_input_keep(
        input logic [PIN_COUNT-1:0] fsel
    );
        logic [PIN_COUNT-1:0] keep;
        keep = INTERRUPT_PINS & fsel;
        // a function-selected debug clock stays sampled
        keep = keep | (DEBUG_CLOCK_PINS & fsel);
        return keep;
    endfunction : stop_input_keep

    // debug data pin in stop drives only while its data is valid,
    // whatever the drive-enable bit says
    function automatic logic debug_hold(
        input logic stop,
        input logic is_debug_pin,
        input logic fsel,
        input logic oe
    );
        return stop && is_debug_pin && fsel && oe;
    endfunction : debug_hold

    // read word of one register; unmapped addresses and bits above the pins read zero
    function automatic logic [DATA_WIDTH-1:0] read_word(
        input logic [ADDR_WIDTH-1:0] addr,
        input gpsg_state_t st
    );
        logic [DATA_WIDTH-1:0] word;
        word = '0;
        case (addr)
            PIN_DATA_OFFSET: word = widen(st.port_in);
            OUTPUT_ENABLE_OFFSET: word = widen(st.output_enable_reg);
            FUNCTION_SELECT_OFFSET: word = widen(st.function_select_reg);
            OPEN_DRAIN_OFFSET: word = widen(st.open_drain_reg);
            PULLUP_OFFSET: word = widen(st.pullup_reg);
            PULLDOWN_OFFSET: word = widen(st.pulldown_reg);
            INPUT_ENABLE_OFFSET: word = widen(st.input_enable_reg);
            STANDBY_CONTROL_OFFSET: begin
                word[STOP_BIT] = st.stop_reg;
                word[DRIVE_ENABLE_BIT] = st.drive_enable_reg;
            end
            PIN_LEVEL_OFFSET: word = widen(st.sync_second);
            default: word = '0;
        endcase
        return word;
    endfunction : read_word

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // one process covers bus slave, registers and pin gating
    always_comb begin
        logic [PIN_COUNT-1:0] in_keep;
        logic [PIN_COUNT-1:0] out_keep;
        logic [PIN_COUNT-1:0] drive_val;
        logic [PIN_COUNT-1:0] drive_en;
        logic [PIN_COUNT-1:0] in_gate;
        logic in_stop;
        logic lane0;
        in_keep = '0;
        out_keep = '0;
        drive_val = '0;
        drive_en = '0;
        in_gate = '0;
        in_stop = 1'b0;
        lane0 = avs_byteenable[0];
        state_next = state_reg;

        // ----------------------------------------
        // pin synchroniser
        // ----------------------------------------
        // pins pass two flops before anything reads them
        // the first stage may go metastable; only the second stage is read
        state_next.sync_first = pin_in;
        state_next.sync_second = state_reg.sync_first;

        // ----------------------------------------
        // register bus slave
        // ----------------------------------------
        // answer after one wait cycle; request held by the master until then
        state_next.waitrequest = 1'b1;
        case (state_reg.bus_state)
            BUS_IDLE: begin
                // read and write are never high together; a write wins if they are
                if (avs_read || avs_write) begin
                    state_next.bus_state = BUS_ANSWER;
                    state_next.waitrequest = 1'b0;
                    state_next.readdata = '0; // unmapped reads return zero
                    // a write lands at the taking edge; pins follow one edge later
                    if (avs_write) begin
                        case (avs_address)
                            PIN_DATA_OFFSET: state_next.pin_data_reg =
                                lane_merge(state_reg.pin_data_reg, avs_writedata, lane0, '1);
                            OUTPUT_ENABLE_OFFSET: state_next.output_enable_reg =
                                lane_merge(state_reg.output_enable_reg, avs_writedata, lane0, '1);
                            FUNCTION_SELECT_OFFSET: state_next.function_select_reg =
                                lane_merge(state_reg.function_select_reg, avs_writedata, lane0,
                                    FUNCTION_SELECT_MASK);
                            OPEN_DRAIN_OFFSET: state_next.open_drain_reg =
                                lane_merge(state_reg.open_drain_reg, avs_writedata, lane0, '1);
                            PULLUP_OFFSET: state_next.pullup_reg =
                                lane_merge(state_reg.pullup_reg, avs_writedata, lane0, PULLUP_MASK);
                            PULLDOWN_OFFSET: state_next.pulldown_reg =
                                lane_merge(state_reg.pulldown_reg, avs_writedata, lane0,
                                    PULLDOWN_MASK);
                            INPUT_ENABLE_OFFSET: state_next.input_enable_reg =
                                lane_merge(state_reg.input_enable_reg, avs_writedata, lane0, '1);
                            STANDBY_CONTROL_OFFSET: begin
                                if (lane0) begin
                                    state_next.drive_enable_reg = avs_writedata[DRIVE_ENABLE_BIT];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end else begin
                        // read data is taken at the same edge and stands for the answer cycle
                        state_next.readdata = read_word(avs_address, state_reg);
                    end
                end
            end
            BUS_ANSWER: begin
                // one idle cycle lets the master drop the request
                state_next.bus_state = BUS_IDLE;
            end
            default: state_next.bus_state = BUS_IDLE;
        endcase

        // ----------------------------------------
        // stop gating
        // ----------------------------------------
        // stop mode follows the clock controller's request
        // stop_request comes from logic on this clock, so it needs no synchroniser
        state_next.stop_reg = stop_request;
        in_stop = state_reg.stop_reg;

        // stop gating: drive-enable keeps own enables, otherwise only exception pins
        if (stop_gated(in_stop, state_reg.drive_enable_reg)) begin
            // the debug clock keeps its input, which is why it blocks deep low power
            in_keep = stop_input_keep(state_reg.function_select_reg);
            out_keep = '0;
        end else begin
            in_keep = '1;
            out_keep = '1;
        end

        // ----------------------------------------
        // pin drive
        // ----------------------------------------
        // output value and enable, port or alternate function per pin
        for (int i = 0; i < PIN_COUNT; i++) begin
            // function pins also need the function's own drive request
            if (state_reg.function_select_reg[i]) begin
                drive_val[i] = alt_out_data[i];
                drive_en[i] = state_reg.output_enable_reg[i] & alt_out_enable[i];
            end else begin
                drive_val[i] = state_reg.pin_data_reg[i];
                drive_en[i] = state_reg.output_enable_reg[i];
            end
            // stop gating first, then the debug and open-drain overrides
            drive_en[i] = drive_en[i] & out_keep[i];
            // debug output in stop drives only while its data is valid
            if (debug_hold(in_stop, DEBUG_OUT_PINS[i], state_reg.function_select_reg[i],
                    state_reg.output_enable_reg[i])) begin
                drive_en[i] = debug_data_valid;
            end
            // pseudo open-drain never drives high
            if (state_reg.open_drain_reg[i] && drive_val[i]) begin
                drive_en[i] = 1'b0;
            end
        end

        // ----------------------------------------
        // input path and outputs
        // ----------------------------------------
        // input gating by enable bit and stop mode
        in_gate = state_reg.input_enable_reg & in_keep;

        state_next.out = drive_val & drive_en;
        state_next.oe = drive_en;
        // pull controls pass straight through; the board applies them
        state_next.pu = state_reg.pullup_reg;
        state_next.pd = state_reg.pulldown_reg;
        // read-back: port pins with input open show the pin level, pins with input gated off show their data if output-enabled
        state_next.port_in = (state_reg.sync_second & in_gate & ~state_reg.function_select_reg)
            | (state_reg.pin_data_reg & state_reg.output_enable_reg & ~in_gate);
        // function pins hand their gated level to the alternate function
        state_next.alt_in = state_reg.sync_second & in_gate & state_reg.function_select_reg;
        // stop status shown one edge after it is taken
        state_next.stop_out = state_reg.stop_reg;

        // ----------------------------------------
        // synchronous reset
        // ----------------------------------------
        // synchronous reset puts the debug pins up
        if (!rst_n) begin
            // outputs and synchroniser restart from zero, except waitrequest, which restarts high
            state_next = '0;
            state_next.bus_state = BUS_IDLE;
            state_next.waitrequest = 1'b1;
            state_next.pin_data_reg = PIN_DATA_RESET;
            state_next.output_enable_reg = OUTPUT_ENABLE_RESET;
            state_next.function_select_reg = FUNCTION_SELECT_RESET;
            state_next.open_drain_reg = OPEN_DRAIN_RESET;
            state_next.pullup_reg = PULLUP_RESET;
            state_next.pulldown_reg = PULLDOWN_RESET;
            state_next.input_enable_reg = INPUT_ENABLE_RESET;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // all state in one register; reset handled in the comb copy
    // no asynchronous reset: one clock, one path, no reset-release hazard
    always_ff @(posedge clock) begin
        state_reg <= state_next;
    end

    // outputs straight from flops
    assign avs_readdata = state_reg.readdata;
    assign avs_waitrequest = state_reg.waitrequest;
    // pin-facing controls, one flop each
    assign pin_out = state_reg.out;
    assign pin_oe = state_reg.oe;
    assign pin_pullup = state_reg.pu;
    assign pin_pulldown = state_reg.pd;
    // core-facing inputs and stop status
    assign port_in_data = state_reg.port_in;
    assign alt_in_data = state_reg.alt_in;
    assign stop_active = state_reg.stop_out;

endmodule : gpsg_port

// File: dv/gpsg_port_properties.sv
// checker: bus handshake and pin relations of the stop-gated gpio port
`timescale 1ns/1ps
module gpsg_port_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] pin_pulldown,
    input wire logic stop_request,
    input wire logic stop_active
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // an access is one answer cycle followed by a forced idle cycle
    sequence s_ask;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    bus_answer_a: assert property (s_ask |-> ##[1:2] s_answer) else $error("bus answer late");
    answer_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
    drive_gate_a: assert property ((pin_out & ~pin_oe) == 8'h00) else $error("value on released pin");
    pulldown_bit_a: assert property ((pin_pulldown & 8'hFD) == 8'h00) else $error("stray pull-down");
    pullup_bit_a: assert property (pin_pullup[1] == 1'b0) else $error("pull-up on pin 1");
    reset_pins_a: assert property ($rose(rst_n) |=> pin_pullup == 8'h01 && pin_pulldown == 8'h02
        && pin_oe[7:1] == 7'h00) else $error("pin reset state");
    stop_follow_a: assert property (stop_request [*3] |-> stop_active) else $error("stop not seen");
endmodule : gpsg_port_properties

bind gpsg_port gpsg_port_properties i_gpsg_port_properties (.clock, .rst_n, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .pin_out, .pin_oe, .pin_pullup, .pin_pulldown, .stop_request, .stop_active);

// File: dv/gpsg_pin_model.sv
// model: board pins with pulls, an external probe driver and floating levels
`timescale 1ns/1ps
module gpsg_pin_model (
    input wire logic clock,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] pin_pulldown,
    input wire logic [7:0] ext_drive,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    logic [7:0] float_reg = 8'h55;
    // an undriven unpulled wire changes every cycle, so a held old value never passes
    always @(posedge clock) float_reg <= ~float_reg;
    // port driver first, then the probe, then the pulls
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drive)
        | (~pin_oe & ~ext_en & (pin_pullup | (~pin_pulldown & float_reg)));
endmodule : gpsg_pin_model

// File: dv/tb_gpio_port_with_stop_gating.sv
// testbench: register access, pin drive, input gating and stop mode of the gpio port
`timescale 1ns/1ps
module tb_gpio_port_with_stop_gating;
    import gpsg_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, stop_active;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown, port_in_data, alt_in_data;
    logic [7:0] alt_out_data = 8'h00;
    logic [7:0] alt_out_enable = 8'h00;
    logic [7:0] ext_drive = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic debug_data_valid = 1'b0;
    logic stop_request = 1'b0;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    // offsets: oe, fsel, od, pullup, pulldown, ie, standby
    logic [7:0] offs [7] = '{8'h04, 8'h08, 8'h28, 8'h2C, 8'h30, 8'h38, 8'h40};
    logic [31:0] rst_v [7] = '{32'h01, 32'h03, 32'h00, 32'h01, 32'h02, 32'h03, 32'h00};
    logic [31:0] one_v [7] = '{32'hFF, 32'h7F, 32'hFF, 32'hFD, 32'h02, 32'hFF, 32'h02};

    gpsg_port i_gpsg_port (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_pulldown, .port_in_data,
        .alt_in_data, .alt_out_data, .alt_out_enable, .debug_data_valid, .stop_request, .stop_active);
    gpsg_pin_model i_gpsg_pin_model (.clock, .pin_out, .pin_oe, .pin_pullup, .pin_pulldown, .ext_drive, .ext_en,
        .pin_in);

    always #25 clock = ~clock;
    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end
    end

    // ----------------------------------------
    // bus tasks and comparison
    // ----------------------------------------
    // request held until waitrequest is sampled low, then one spare edge before the next
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check($sformatf("register %h", a), rd, exp);
    endtask : rchk
    // a drive change seen back at the inputs takes four edges, plus one to look
    task automatic settle;
        repeat (5) @(posedge clock);
    endtask : settle
    task automatic conclude;
        if (bad_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        check("pin_pullup", pin_pullup, 8'h01);
        check("pin_pulldown", pin_pulldown, 8'h02);
        check("pin_oe", pin_oe, 8'h00);
        for (int i = 0; i < 7; i++) rchk(offs[i], rst_v[i]);
        rchk(8'h00, 32'h0);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, offs[i], 32'hFFFF_FFFF);
            rchk(offs[i], one_v[i]);
        end
        bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
        rchk(8'h3C, 32'h0);
        // lane 0 off leaves the register untouched
        avs_byteenable <= 4'hE;
        bus(1'b1, 8'h04, 32'h0);
        avs_byteenable <= 4'hF;
        rchk(8'h04, 32'hFF);
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h38, 32'h0);
        bus(1'b1, 8'h28, 32'h0);
        bus(1'b1, 8'h00, 32'hA5);
        settle();
        check("pin_oe", pin_oe, 8'hFF);
        check("pin_out", pin_out, 8'hA5);
        rchk(8'h00, 32'hA5);
        bus(1'b1, 8'h28, 32'hFF);
        bus(1'b1, 8'h2C, 32'hF0);
        bus(1'b1, 8'h30, 32'h0);
        settle();
        check("pin_oe", pin_oe, 8'h5A);
        check("pin_out", pin_out, 8'h00);
        check("pin_pullup", pin_pullup, 8'hF0);
        check("pin_pulldown", pin_pulldown, 8'h00);
        bus(1'b1, 8'h28, 32'h0);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h38, 32'h0F);
        ext_en <= 8'hFF;
        ext_drive <= 8'h3C;
        settle();
        check("port_in_data", port_in_data, 8'h0C);
        rchk(8'h00, 32'h0C);
        rchk(8'h44, 32'h3C);
        bus(1'b1, 8'h04, 32'h01);
        bus(1'b1, 8'h08, 32'h03);
        alt_out_enable <= 8'h01;
        alt_out_data <= 8'h01;
        ext_en <= 8'h02;
        ext_drive <= 8'h02;
        settle();
        check("pin_oe", pin_oe, 8'h01);
        check("alt_in_data", alt_in_data[1:0], 2'b11);
        // stop mode, drive enable set: enables still rule on pins 1 to 7
        bus(1'b1, 8'h08, 32'h01);
        bus(1'b1, 8'h04, 32'hFF);
        bus(1'b1, 8'h38, 32'hFF);
        bus(1'b1, 8'h00, 32'hFC);
        bus(1'b1, 8'h40, 32'h02);
        ext_en <= 8'h00;
        stop_request <= 1'b1;
        settle();
        check("pin_oe", pin_oe[7:1], 7'h7F);
        check("port_in_data", port_in_data, 8'hFC);
        check("stop_active", stop_active, 1'b1);
        bus(1'b1, 8'h40, 32'h0);
        debug_data_valid <= 1'b1;
        settle();
        check("pin_oe", pin_oe, 8'h01);
        check("port_in_data", port_in_data, 8'hFC);
        check("alt_in_data", alt_in_data, 8'h00);
        rchk(8'h40, 32'h01);
        debug_data_valid <= 1'b0;
        settle();
        check("pin_oe", pin_oe, 8'h00);
        stop_request <= 1'b0;
        settle();
        check("pin_oe", pin_oe[7:1], 7'h7F);
        conclude();
    end
endmodule : tb_gpio_port_with_stop_gating
